// ---- rtl/eqo_pkg.sv ----
package eqo_pkg;

    // ========================================
    // register bus
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam logic [11:0] QUAD_CFG_ADDR   = 12'h884;
    localparam logic [11:0] INDEX_CFG_ADDR  = 12'h885;

    // ========================================
    // quad_output_config fields
    localparam int          QC_RATE_LSB     = 0;
    localparam int          QC_RATE_W       = 4;
    localparam int          QC_ADS_BIT      = 4;
    localparam int          QC_RBW_LSB      = 5;
    localparam int          QC_SE_BIT       = 7;
    localparam logic [7:0]  QUAD_CFG_RESET  = 8'h00;

    // ========================================
    // index_output_config fields
    localparam int          IC_GATE_LSB     = 0;
    localparam int          IC_SE_BIT       = 3;
    localparam int          IC_LN_BIT       = 6;
    localparam logic [7:0]  INDEX_CFG_RESET = 8'h40;
    localparam logic [7:0]  INDEX_CFG_WMASK = 8'h4b;

    // ========================================
    // rate codes and gating codes
    localparam logic [3:0]  RATE_MULT_MAX   = 4'h3;
    localparam logic [3:0]  RATE_RESERVED   = 4'h4;
    localparam logic [3:0]  RATE_DIV_BASE   = 4'h4;
    localparam logic [1:0]  GATE_NONE       = 2'h0;
    localparam logic [1:0]  GATE_A          = 2'h1;
    localparam logic [1:0]  GATE_B          = 2'h2;
    localparam logic [1:0]  GATE_AB         = 2'h3;

    // ========================================
    // rate engine sizing
    localparam int          PERIOD_W        = 16;
    localparam int          POS_W           = 13;
    localparam int          PEND_W          = 8;

    typedef enum logic [1:0] {
        EQO_IDX_IDLE,
        EQO_IDX_ARMED,
        EQO_IDX_PULSE
    } eqo_idx_state_t;

endpackage

// ---- rtl/eqo_rate.sv ----
`timescale 1ns/10ps
module eqo_rate #(
    parameter int PERIOD_W = eqo_pkg::PERIOD_W,
    parameter int POS_W    = eqo_pkg::POS_W,
    parameter int PEND_W   = eqo_pkg::PEND_W
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [3:0] rate_code,
    input  wire logic       native_a,
    input  wire logic       native_b,
    output logic            quad_a,
    output logic            quad_b
);

    // ========================================
    // helpers
    // quadrature level pair to 2-bit count, a leads b when counting up
    function automatic logic [1:0] qbin(input logic a, input logic b);
        qbin = {b, a ^ b};
    endfunction

    // ========================================
    // rate decode
    logic [1:0] mult_exp;
    logic [3:0] div_exp;

    always_comb begin
        mult_exp = 2'h0;
        div_exp  = 4'h0;
        if (rate_code <= eqo_pkg::RATE_MULT_MAX) begin
            mult_exp = rate_code[1:0];
        end else if (rate_code != eqo_pkg::RATE_RESERVED) begin
            div_exp  = rate_code - eqo_pkg::RATE_DIV_BASE;
        end
        // reserved code leaves both at zero: native edges
    end

    // ========================================
    // native edge detect, period measure, interpolation, division
    logic [1:0]          nat_q, nat_d, nat_now, delta;
    logic                edge_up, edge_dn;
    logic [PERIOD_W-1:0] cnt_q, cnt_d, period_q, period_d, pace_q, pace_d, interval;
    logic [PEND_W-1:0]   pend_q, pend_d, n_step, pend_abs;
    logic [1:0]          fine_q, fine_d;
    logic [POS_W-1:0]    pos_q, pos_d, pos_sh;
    logic                qa_d, qb_d, qa_q, qb_q, step;
    logic [1:0]          out_s;

    always_comb begin
        nat_now  = qbin(native_a, native_b);
        delta    = nat_now - nat_q;
        edge_up  = (delta == 2'h1);
        edge_dn  = (delta == 2'h3);
        nat_d    = nat_now;
        n_step   = PEND_W'(1) << mult_exp;
        interval = period_q >> mult_exp;
        if (interval == '0) begin
            interval = PERIOD_W'(1);
        end
        cnt_d    = (&cnt_q) ? cnt_q : cnt_q + PERIOD_W'(1);
        period_d = period_q;
        pace_d   = pace_q + PERIOD_W'(1);
        pend_d   = pend_q;
        fine_d   = fine_q;
        pos_d    = pos_q;
        pend_abs = pend_q[PEND_W-1] ? PEND_W'(-pend_q) : pend_q;
        // a late native edge is paced; a backlog larger than one edge flushes each cycle
        step     = (pend_q != '0) && ((pace_q >= interval) || (pend_abs > n_step));
        if (step) begin
            pace_d = '0;
            if (pend_q[PEND_W-1]) begin
                fine_d = fine_q - 2'h1;
                pend_d = pend_q + PEND_W'(1);
            end else begin
                fine_d = fine_q + 2'h1;
                pend_d = pend_q - PEND_W'(1);
            end
        end
        if (edge_up || edge_dn) begin
            period_d = cnt_q;
            cnt_d    = PERIOD_W'(1);
            pace_d   = '0;
            pend_d   = edge_up ? pend_d + n_step : pend_d - n_step;
            pos_d    = edge_up ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
        end
        pos_sh = pos_q >> div_exp;
        if (mult_exp != 2'h0) begin
            out_s = fine_q;
        end else if (div_exp != 4'h0) begin
            out_s = pos_sh[1:0];
        end else begin
            out_s = nat_q;
        end
        qa_d = out_s[1] ^ out_s[0];
        qb_d = out_s[1];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nat_q    <= '0;
            cnt_q    <= '0;
            period_q <= '1;
            pace_q   <= '0;
            pend_q   <= '0;
            fine_q   <= '0;
            pos_q    <= '0;
            qa_q     <= 1'b0;
            qb_q     <= 1'b0;
        end else begin
            nat_q    <= nat_d;
            cnt_q    <= cnt_d;
            period_q <= period_d;
            pace_q   <= pace_d;
            pend_q   <= pend_d;
            fine_q   <= fine_d;
            pos_q    <= pos_d;
            qa_q     <= qa_d;
            qb_q     <= qb_d;
        end
    end

    assign quad_a = qa_q;
    assign quad_b = qb_q;

endmodule

// ---- rtl/eqo_top.sv ----
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - rate_select picks none, x2, x4, x8, or divide by 2 up to 2048.
// - analog_digital_select 0 routes analog quadrature outputs, 1 routes digital ones.
// - differential digital mode drives all four digital quadrature pins.
// - single-ended digital mode drives positive A and B only, negatives floating.
// - quadrature single-ended select has no effect while analog mode is chosen.
// - negative index output is always the inverse of positive index output.
// - positive index output is low except one high pulse per revolution.
// - index single-ended select 0 drives both index pins complementary.
// - index single-ended select 1 floats negative index, drives positive only.
// - gating 00: positive index follows the Z comparator directly.
// - gating 01: pulse from first A fall after Z rises to next A rise.
// - gating 10: pulse from first B fall after Z rises to next B rise.
// - gating 11: A fall with B low or B fall with A low, ends next rise.
// - gating starts only on falling quadrature edges, positive Z differential.
// - differential digital negative outputs invert positive ones at every rate.
// - analog mode floats the digital pins; digital mode floats the analog pins.
module eqo_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // comparator levels, asynchronous
    input  wire logic        comp_a,
    input  wire logic        comp_b,
    input  wire logic        comp_z,
    // digital quadrature pins
    output logic             a_pos_digital_out,
    output logic             a_pos_digital_oe,
    output logic             a_neg_digital_out,
    output logic             a_neg_digital_oe,
    output logic             b_pos_digital_out,
    output logic             b_pos_digital_oe,
    output logic             b_neg_digital_out,
    output logic             b_neg_digital_oe,
    // analog quadrature driver enables
    output logic             a_pos_analog_oe,
    output logic             a_neg_analog_oe,
    output logic             b_pos_analog_oe,
    output logic             b_neg_analog_oe,
    // index pins
    output logic             index_pos_out,
    output logic             index_pos_oe,
    output logic             index_neg_out,
    output logic             index_neg_oe,
    // analog front end bandwidth control
    output logic             low_noise_select
);

    // ========================================
    // register file
    logic [7:0] qreg_q, qreg_d;
    logic [7:0] icfg_q, icfg_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        qreg_d  = qreg_q;
        icfg_d  = icfg_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            if (reg_addr == eqo_pkg::QUAD_CFG_ADDR) begin
                // bandwidth field stored as written; software keeps it at 00
                qreg_d = reg_wdata;
            end
            if (reg_addr == eqo_pkg::INDEX_CFG_ADDR) begin
                icfg_d = reg_wdata & eqo_pkg::INDEX_CFG_WMASK;
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                eqo_pkg::QUAD_CFG_ADDR: begin
                    rdata_d = qreg_q;
                end
                eqo_pkg::INDEX_CFG_ADDR: begin
                    rdata_d = icfg_q & eqo_pkg::INDEX_CFG_WMASK;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qreg_q  <= eqo_pkg::QUAD_CFG_RESET;
            icfg_q  <= eqo_pkg::INDEX_CFG_RESET;
            rdata_q <= 8'h00;
        end else begin
            qreg_q  <= qreg_d;
            icfg_q  <= icfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ========================================
    // configuration fields
    logic [3:0] rate_select;
    logic       analog_digital_select;
    logic       quad_single_ended;
    logic [1:0] index_gating_select;
    logic       index_single_ended;

    always_comb begin
        rate_select           = qreg_q[eqo_pkg::QC_RATE_LSB +: eqo_pkg::QC_RATE_W];
        analog_digital_select = qreg_q[eqo_pkg::QC_ADS_BIT];
        quad_single_ended     = qreg_q[eqo_pkg::QC_SE_BIT];
        index_gating_select   = icfg_q[eqo_pkg::IC_GATE_LSB +: 2];
        index_single_ended    = icfg_q[eqo_pkg::IC_SE_BIT];
    end

    // ========================================
    // comparator synchronisers
    // first stage feeds only the second stage; metastability stays contained
    logic [2:0] sync1_q, sync2_q;
    logic       z_prev_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q  <= 3'h0;
            sync2_q  <= 3'h0;
            z_prev_q <= 1'b0;
        end else begin
            sync1_q  <= {comp_z, comp_b, comp_a};
            sync2_q  <= sync1_q;
            z_prev_q <= sync2_q[2];
        end
    end

    // ========================================
    // rate engine
    logic quad_a, quad_b;

    eqo_rate u_rate (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .rate_code (rate_select),
        .native_a  (sync2_q[0]),
        .native_b  (sync2_q[1]),
        .quad_a    (quad_a),
        .quad_b    (quad_b)
    );

    // ========================================
    // quadrature pin drive
    logic a_out_q, a_out_d, b_out_q, b_out_d;
    logic an_out_q, an_out_d, bn_out_q, bn_out_d;
    logic dpos_oe_q, dpos_oe_d, dneg_oe_q, dneg_oe_d, ana_oe_q, ana_oe_d;

    always_comb begin
        a_out_d   = quad_a;
        b_out_d   = quad_b;
        an_out_d  = ~quad_a;
        bn_out_d  = ~quad_b;
        // analog mode: single-ended select is ignored
        dpos_oe_d = analog_digital_select;
        dneg_oe_d = analog_digital_select & ~quad_single_ended;
        ana_oe_d  = ~analog_digital_select;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            a_out_q   <= 1'b0;
            b_out_q   <= 1'b0;
            an_out_q  <= 1'b1;
            bn_out_q  <= 1'b1;
            dpos_oe_q <= 1'b0;
            dneg_oe_q <= 1'b0;
            ana_oe_q  <= 1'b0;
        end else begin
            a_out_q   <= a_out_d;
            b_out_q   <= b_out_d;
            an_out_q  <= an_out_d;
            bn_out_q  <= bn_out_d;
            dpos_oe_q <= dpos_oe_d;
            dneg_oe_q <= dneg_oe_d;
            ana_oe_q  <= ana_oe_d;
        end
    end

    assign a_pos_digital_out = a_out_q;
    assign b_pos_digital_out = b_out_q;
    assign a_neg_digital_out = an_out_q;
    assign b_neg_digital_out = bn_out_q;
    assign a_pos_digital_oe  = dpos_oe_q;
    assign b_pos_digital_oe  = dpos_oe_q;
    assign a_neg_digital_oe  = dneg_oe_q;
    assign b_neg_digital_oe  = dneg_oe_q;
    assign a_pos_analog_oe   = ana_oe_q;
    assign a_neg_analog_oe   = ana_oe_q;
    assign b_pos_analog_oe   = ana_oe_q;
    assign b_neg_analog_oe   = ana_oe_q;

    // ========================================
    // index gating
    // edges are taken against the registered pins so the pulse edge
    // lands in the same cycle as the quadrature pin edge
    eqo_pkg::eqo_idx_state_t idx_state_q, idx_state_d;
    logic z_now, z_rise;
    logic a_fall, a_rise, b_fall, b_rise;
    logic gate_start, gate_end;
    logic idx_pos_q, idx_pos_d, idx_neg_q, idx_neg_d;
    logic idx_neg_oe_q, idx_neg_oe_d, idx_pos_oe_q, idx_pos_oe_d;

    always_comb begin
        z_now  = sync2_q[2];
        z_rise = z_now & ~z_prev_q;
        a_fall = a_out_q & ~quad_a;
        a_rise = ~a_out_q & quad_a;
        b_fall = b_out_q & ~quad_b;
        b_rise = ~b_out_q & quad_b;
        // only the falling quadrature polarity is offered
        case (index_gating_select)
            eqo_pkg::GATE_A: begin
                gate_start = a_fall;
                gate_end   = a_rise;
            end
            eqo_pkg::GATE_B: begin
                gate_start = b_fall;
                gate_end   = b_rise;
            end
            eqo_pkg::GATE_AB: begin
                gate_start = (a_fall & ~quad_b) | (b_fall & ~quad_a);
                gate_end   = a_rise | b_rise;
            end
            default: begin
                gate_start = 1'b0;
                gate_end   = 1'b0;
            end
        endcase

        idx_state_d = idx_state_q;
        case (idx_state_q)
            eqo_pkg::EQO_IDX_IDLE: begin
                if (z_rise) begin
                    idx_state_d = eqo_pkg::EQO_IDX_ARMED;
                end
            end
            eqo_pkg::EQO_IDX_ARMED: begin
                if (gate_start) begin
                    idx_state_d = eqo_pkg::EQO_IDX_PULSE;
                end
            end
            eqo_pkg::EQO_IDX_PULSE: begin
                if (gate_end) begin
                    idx_state_d = eqo_pkg::EQO_IDX_IDLE;
                end
            end
            default: begin
                idx_state_d = eqo_pkg::EQO_IDX_IDLE;
            end
        endcase
        if (index_gating_select == eqo_pkg::GATE_NONE) begin
            idx_state_d = eqo_pkg::EQO_IDX_IDLE;
            idx_pos_d   = z_now;
        end else begin
            // one pulse per Z window, low otherwise
            idx_pos_d   = (idx_state_d == eqo_pkg::EQO_IDX_PULSE);
        end
        idx_neg_d    = ~idx_pos_d;
        idx_pos_oe_d = 1'b1;
        idx_neg_oe_d = ~index_single_ended;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx_state_q  <= eqo_pkg::EQO_IDX_IDLE;
            idx_pos_q    <= 1'b0;
            idx_neg_q    <= 1'b1;
            idx_pos_oe_q <= 1'b0;
            idx_neg_oe_q <= 1'b0;
        end else begin
            idx_state_q  <= idx_state_d;
            idx_pos_q    <= idx_pos_d;
            idx_neg_q    <= idx_neg_d;
            idx_pos_oe_q <= idx_pos_oe_d;
            idx_neg_oe_q <= idx_neg_oe_d;
        end
    end

    assign index_pos_out = idx_pos_q;
    assign index_neg_out = idx_neg_q;
    assign index_pos_oe  = idx_pos_oe_q;
    assign index_neg_oe  = idx_neg_oe_q;

    // ========================================
    // front end bandwidth
    logic ln_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ln_q <= 1'b1;
        end else begin
            // software must keep this set
            ln_q <= icfg_q[eqo_pkg::IC_LN_BIT];
        end
    end

    assign low_noise_select = ln_q;

endmodule

// ---- verif/eqo_top_asserts.sv ----
`timescale 1ns/10ps
module eqo_top_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        comp_z,
    input wire logic        a_pos_digital_out,
    input wire logic        a_pos_digital_oe,
    input wire logic        a_neg_digital_out,
    input wire logic        a_neg_digital_oe,
    input wire logic        b_pos_digital_out,
    input wire logic        b_neg_digital_out,
    input wire logic        b_neg_digital_oe,
    input wire logic        a_pos_analog_oe,
    input wire logic        index_pos_out,
    input wire logic        index_neg_out,
    input wire logic        index_neg_oe
);
    // ========================================
    // shadow of both config bytes, rebuilt from the port
    logic [7:0] qc_q, qc_d, ic_q, ic_d;
    logic [2:0] gst_q, gst_d;
    logic       live_q;
    wire        wr_q = reg_wr && reg_addr == eqo_pkg::QUAD_CFG_ADDR;
    wire        wr_i = reg_wr && reg_addr == eqo_pkg::INDEX_CFG_ADDR;
    wire        unmapped = reg_addr != eqo_pkg::QUAD_CFG_ADDR && reg_addr != eqo_pkg::INDEX_CFG_ADDR;
    always_comb begin
        qc_d = wr_q ? reg_wdata : qc_q;
        ic_d = wr_i ? (reg_wdata & eqo_pkg::INDEX_CFG_WMASK) : ic_q;
        // gating checks wait until a mode change has flushed the pipe
        gst_d = wr_i ? 3'h0 : gst_q + {2'h0, gst_q != 3'h7};
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qc_q   <= eqo_pkg::QUAD_CFG_RESET;
            ic_q   <= eqo_pkg::INDEX_CFG_RESET;
            gst_q  <= 3'h0;
            live_q <= 1'h0;
        end else begin
            qc_q   <= qc_d;
            ic_q   <= ic_d;
            gst_q  <= gst_d;
            live_q <= 1'h1;
        end
    end

    // ========================================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_settled(g);
        ic_q[1:0] == g && gst_q > 3'h4;
    endsequence
    property p_gate(g, up_ok, dn_ok);
        s_settled(g) |-> (!$rose(index_pos_out) || up_ok) && (!$fell(index_pos_out) || dn_ok);
    endproperty

    a_idx_inverse: assert property (index_neg_out == !index_pos_out)
        else $error("index outputs not complementary");
    a_quad_inverse: assert property (a_neg_digital_oe |->
        a_neg_digital_out == !a_pos_digital_out && b_neg_digital_out == !b_pos_digital_out)
        else $error("negative quadrature outputs not inverted");
    a_mode_oe: assert property (live_q |-> a_pos_digital_oe == $past(qc_q[4])
        && a_pos_analog_oe == !$past(qc_q[4])) else $error("analog or digital enables wrong");
    a_neg_drive: assert property (live_q |-> b_neg_digital_oe == a_neg_digital_oe
        && a_neg_digital_oe == ($past(qc_q[4]) && !$past(qc_q[7]))) else $error("negative enables wrong");
    a_index_se: assert property (live_q |-> index_neg_oe == !$past(ic_q[3]))
        else $error("index negative enable wrong");
    a_read_quad: assert property (s_rd(eqo_pkg::QUAD_CFG_ADDR) |=> reg_rdata == $past(qc_q))
        else $error("quad config read wrong");
    a_read_index: assert property (s_rd(eqo_pkg::INDEX_CFG_ADDR) |=> reg_rdata == $past(ic_q))
        else $error("index config read wrong");
    a_read_idle: assert property ((!reg_rd || unmapped) |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    a_ungated: assert property (s_settled(eqo_pkg::GATE_NONE) |-> index_pos_out == $past(comp_z, 3))
        else $error("ungated index does not follow comparator");
    a_gate_by_a: assert property (p_gate(eqo_pkg::GATE_A, $fell(a_pos_digital_out),
        $rose(a_pos_digital_out))) else $error("index gated by a misplaced");
    a_gate_by_b: assert property (p_gate(eqo_pkg::GATE_B, $fell(b_pos_digital_out),
        $rose(b_pos_digital_out))) else $error("index gated by b misplaced");
    a_gate_by_ab: assert property (p_gate(eqo_pkg::GATE_AB,
        ($fell(a_pos_digital_out) && !b_pos_digital_out) || ($fell(b_pos_digital_out) && !a_pos_digital_out),
        $rose(a_pos_digital_out) || $rose(b_pos_digital_out))) else $error("index gated by a and b misplaced");
endmodule

bind eqo_top eqo_top_asserts eqo_top_asserts_inst (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .comp_z,
    .a_pos_digital_out, .a_pos_digital_oe, .a_neg_digital_out, .a_neg_digital_oe, .b_pos_digital_out,
    .b_neg_digital_out, .b_neg_digital_oe, .a_pos_analog_oe, .index_pos_out, .index_neg_out, .index_neg_oe
);

// ---- verif/eqo_decoder_model.sv ----
`timescale 1ns/10ps
module eqo_decoder_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        a_in,
    input  wire logic        a_oe,
    input  wire logic        b_in,
    input  wire logic        b_oe,
    input  wire logic        z_in,
    input  wire logic        z_oe,
    output logic      [15:0] pos,
    output logic      [7:0]  idx_cnt
);
    // ========================================
    // undriven lines wobble instead of holding their last level
    logic       a_q, b_q, z_q;
    logic [1:0] st_q;
    wire        a_w = a_oe ? a_in : ~a_q;
    wire        b_w = b_oe ? b_in : ~b_q;
    wire        z_w = z_oe ? z_in : ~z_q;
    wire  [1:0] st_w = {b_w, a_w ^ b_w};
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {a_q, b_q, z_q, st_q} <= 5'h00;
            pos <= 16'h0000;
            idx_cnt <= 8'h00;
        end else begin
            {a_q, b_q, z_q, st_q} <= {a_w, b_w, z_w, st_w};
            // a half-turn jump has no direction
            if (st_w - st_q == 2'h1) begin
                pos <= pos + 16'h0001;
            end else if (st_w - st_q == 2'h3) begin
                pos <= pos - 16'h0001;
            end
            if (z_w && !z_q) begin
                idx_cnt <= idx_cnt + 8'h01;
            end
        end
    end
endmodule

// ---- verif/test_encoder_quad_index_output.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module test_encoder_quad_index_output;
    localparam logic [11:0] QA = eqo_pkg::QUAD_CFG_ADDR;
    localparam logic [11:0] IA = eqo_pkg::INDEX_CFG_ADDR;
    logic        clk_sys = 1'h0;
    logic        rst_n, reg_wr, reg_rd, comp_z;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rv, d, i0, idx_cnt;
    logic [15:0] rnd, p0, pos;
    logic [1:0]  s;
    logic        a_pos_digital_out, a_pos_digital_oe, a_neg_digital_out, a_neg_digital_oe;
    logic        b_pos_digital_out, b_pos_digital_oe, b_neg_digital_out, b_neg_digital_oe;
    logic        a_pos_analog_oe, a_neg_analog_oe, b_pos_analog_oe, b_neg_analog_oe;
    logic        index_pos_out, index_pos_oe, index_neg_out, index_neg_oe, low_noise_select;
    wire         comp_a = s[1] ^ s[0];
    wire         comp_b = s[1];
    int          n_fail = 0, checked = 0, cyc = 0;

    eqo_top eqo_top_inst (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .comp_a, .comp_b, .comp_z,
        .a_pos_digital_out, .a_pos_digital_oe, .a_neg_digital_out, .a_neg_digital_oe, .b_pos_digital_out,
        .b_pos_digital_oe, .b_neg_digital_out, .b_neg_digital_oe, .a_pos_analog_oe, .a_neg_analog_oe,
        .b_pos_analog_oe, .b_neg_analog_oe, .index_pos_out, .index_pos_oe, .index_neg_out, .index_neg_oe,
        .low_noise_select
    );
    eqo_decoder_model eqo_decoder_model_inst (
        .clk_sys, .rst_n, .a_in(a_pos_digital_out), .a_oe(a_pos_digital_oe), .b_in(b_pos_digital_out),
        .b_oe(b_pos_digital_oe), .z_in(index_pos_out), .z_oe(index_pos_oe), .pos, .idx_cnt
    );

    always #2.5 clk_sys = ~clk_sys;

    // ========================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // interpolation multiplies 16 native steps; each division run yields two output steps
    function automatic logic [15:0] rate_exp(input logic [3:0] c);
        if (c < 4'h4) return 16'h0010 << c;
        return (c == 4'h4) ? 16'h0010 : 16'h0002;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 rv = reg_rdata;
    endtask
    task automatic step(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge clk_sys);
            s <= s + 2'h1;
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d of %0d comparisons", n_fail, checked);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // longest path is the divide-by-2048 run; ceiling leaves margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            finish_test;
        end
    end

    // ========================================
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, comp_z, s, reg_addr, reg_wdata} = 26'h0;
        rnd = 16'h000f;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(QA);
        `CHK("quad reset", 8'h00, rv)
        rd(IA);
        `CHK("index reset", 8'h40, rv)
        `CHK("analog oe", 1'h1, a_pos_analog_oe)
        `CHK("low noise", 1'h1, low_noise_select)
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0] | 8'h40; // low-noise bit always written as one
            wr(IA, d);
            rd(IA);
            `CHK("index cfg", d & 8'h4b, rv)
            wr(QA, rnd[15:8] & 8'h9f); // bandwidth field kept at zero
            rd(QA);
            `CHK("quad cfg", rnd[15:8] & 8'h9f, rv)
            wr(12'h886, d);
            rd(12'h886);
            `CHK("unmapped", 8'h00, rv)
        end
        for (int m = 0; m < 4; m++) begin
            wr(QA, {m[1], 2'h0, m[0], 4'h0});
            repeat (3) @(posedge clk_sys);
            `CHK("digital oe", m[0], a_pos_digital_oe)
            `CHK("negative oe", m[0] & ~m[1], b_neg_digital_oe)
            `CHK("analog oe", {3{~m[0]}}, {a_neg_analog_oe, b_pos_analog_oe, b_neg_analog_oe})
        end
        for (int c = 0; c < 16; c++) begin
            wr(QA, {4'h1, c[3:0]});
            repeat (40) @(posedge clk_sys);
            p0 = pos;
            step(c <= 4 ? 16 : 2 << (c - 4), c < 4 ? 64 : 6);
            repeat (200) @(posedge clk_sys);
            `CHK("rate steps", rate_exp(c[3:0]), pos - p0)
        end
        wr(QA, 8'h10);
        for (int g = 0; g < 8; g++) begin
            wr(IA, {4'h4, g[2], 1'h0, g[1:0]});
            repeat (10) @(posedge clk_sys);
            i0 = idx_cnt;
            rnd = lfsr(rnd);
            comp_z <= 1'h1;
            step(8, 10 + int'(rnd[3:0]));
            comp_z <= 1'h0;
            step(8, 16);
            repeat (20) @(posedge clk_sys);
            `CHK("index pulses", 8'h01, idx_cnt - i0)
            `CHK("index neg oe", ~g[2], index_neg_oe)
        end
        finish_test;
    end
endmodule
